// *** common/freq_prot_defs.vh ***
// constants for the frequency protection block
`ifndef FREQ_PROT_DEFS_VH
`define FREQ_PROT_DEFS_VH

// timing
`define CLK_PERIOD_NS 5
`define PROC_CYCLE_US 5000
`define PRETRIG_MS 20
// pick-up hysteresis, 20 mHz in 0.01 Hz steps
`define HYST_STEPS 16'h0002

// reset values
`define THR_OVER_RST 16'h13ec
`define THR_UNDER_RST 16'h1324
`define DLY_RST 19'h00008
`define REL_RST 16'h000c
`define CTRL_RST 32'h00000008
`define EVMASK_RST 6'h3f

// register offsets
`define REG_CTRL 12'h000
`define REG_ENABLE 12'h004
`define REG_FORCE 12'h008
`define REG_UVBLK 12'h00c
`define REG_RELTIME 12'h010
`define REG_EVMASK 12'h014
`define REG_CNTCLR 12'h018
`define REG_STATUS 12'h01c
`define REG_TIME 12'h020
`define REG_LOGPTR 12'h024
`define REG_STAGE_BASE 12'h100
`define REG_GRP_BASE 12'h200
`define REG_LOG_BASE 12'h400

// control fields
`define CTRL_REF_LSB 0
`define CTRL_FORCE_BIT 2
`define CTRL_RELEN_BIT 3
`define CTRL_GRP_LSB 4

// stage conditions
`define ST_NORMAL 2'h0
`define ST_START 2'h1
`define ST_TRIP 2'h2
`define ST_BLOCKED 2'h3

`endif

// *** logic/freq_log.v ***
// circular log of the last operations
`timescale 1ns/100ps
`default_nettype none

module freq_log #(
    parameter DEPTH = 12
) (
    // clock
    input wire clk_in,
    input wire rst_in,
    // new entry
    input wire wr_in,
    input wire [31:0] time_in,
    input wire [2:0] stage_in,
    input wire [2:0] code_in,
    input wire [2:0] grp_in,
    input wire [15:0] pre_in,
    input wire [15:0] fault_in,
    // readback
    input wire [3:0] rd_idx_in,
    input wire [1:0] rd_word_in,
    output reg [31:0] rd_data_out,
    output reg [3:0] ptr_out
);
    reg [31:0] time_mem [0:DEPTH-1];
    reg [8:0] name_mem [0:DEPTH-1];
    reg [31:0] freq_mem [0:DEPTH-1];
    integer i;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_out <= 4'h0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                time_mem[i] <= 32'h0;
                name_mem[i] <= 9'h0;
                freq_mem[i] <= 32'h0;
            end
        end else if (wr_in) begin
            time_mem[ptr_out] <= time_in;
            name_mem[ptr_out] <= {grp_in, stage_in, code_in};
            freq_mem[ptr_out] <= {fault_in, pre_in};
            // oldest entry is overwritten once the ring is full
            ptr_out <= (ptr_out == DEPTH - 1) ? 4'h0 : ptr_out + 4'h1;
        end
    end

    always @* begin
        rd_data_out = 32'h0;
        if (rd_idx_in < DEPTH) begin
            case (rd_word_in)
                2'h0: rd_data_out = time_mem[rd_idx_in];
                2'h1: rd_data_out = {23'h0, name_mem[rd_idx_in]};
                2'h2: rd_data_out = {16'h0, freq_mem[rd_idx_in][15:0]};
                default: rd_data_out = {16'h0, freq_mem[rd_idx_in][31:16]};
            endcase
        end
    end
endmodule // freq_log

`default_nettype wire

// *** logic/freq_protection.v ***
// frequency protection: eight stages, events, counters, log, apb registers
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "freq_prot_defs.vh"

module freq_protection #(
    parameter integer CYCLE_CYC = `PROC_CYCLE_US * 1000 / `CLK_PERIOD_NS,
    parameter NSTAGE = 8,
    parameter NGRP = 8
) (
    // clock and reset
    input wire REF_CLK_IN,
    input wire RESET_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [11:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output reg [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    // measurements and blocking matrix
    input wire [15:0] FREQ_REF1_IN,
    input wire [15:0] FREQ_REF2_IN,
    input wire [15:0] FREQ_REF3_IN,
    input wire [15:0] VOLT_IN,
    input wire [7:0] BLOCK_IN,
    // stage outputs
    output reg [7:0] START_OUT,
    output reg [7:0] TRIP_OUT,
    output reg [7:0] BLOCKED_OUT,
    // event stream
    output reg EVT_VALID_OUT,
    output reg [2:0] FREQ_EVENT_BLOCK_OUT,
    output reg [2:0] EVT_CODE_OUT,
    output reg [31:0] EVT_TIME_OUT
);
    localparam PRE_DEPTH = `PRETRIG_MS * 1000 / `PROC_CYCLE_US;
    localparam NEV = NSTAGE * 6;

    // {blocked, trip, start} seen in a condition code
    function [2:0] flags;
        input [1:0] st;
        begin
            flags = {st == `ST_BLOCKED, st == `ST_TRIP,
                     (st == `ST_START) || (st == `ST_TRIP)};
        end
    endfunction

    // lowest pending event
    function [5:0] first_set;
        input [NEV-1:0] v;
        integer k;
        begin
            first_set = 6'h0;
            for (k = NEV - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_set = k[5:0];
                end
            end
        end
    endfunction

    // mapped address check shared by read and write
    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a[11:6] == 6'h0 && a[5:2] <= 4'h9 && a[1:0] == 2'h0)
                || (a[11:8] == 4'h1 && a[7] == 1'b0 && a[1:0] == 2'h0)
                || (a[11:9] == 3'h1 && a[1:0] == 2'h0)
                || (a[11:10] == 2'h1 && a[9:8] == 2'h0 && a[7:4] < 4'hc
                    && a[1:0] == 2'h0);
        end
    endfunction

    // settings
    reg [31:0] ctrl_r;
    reg [7:0] enable_r;
    reg [15:0] force_r;
    reg [15:0] uvblk_r;
    reg [15:0] rel_r;
    reg [5:0] evmask_r;
    reg [15:0] thr_mem [0:NSTAGE*NGRP-1];
    reg [18:0] dly_mem [0:NSTAGE*NGRP-1];
    reg [NSTAGE*NGRP-1:0] used_r;
    // processing cycle
    reg [31:0] div_r;
    reg tick_r;
    reg eval_r;
    reg [31:0] time_r;
    reg [7:0] blk_r;
    reg uv_r;
    reg [15:0] freq_r;
    reg [15:0] hist_r [0:PRE_DEPTH-1];
    // events and counters
    reg [23:0] flag_r;
    reg [NEV-1:0] pend_r;
    reg [15:0] cnt_mem [0:NSTAGE*3-1];
    integer i, j, m, n;

    wire [1:0] ref_sel = ctrl_r[`CTRL_REF_LSB+1:`CTRL_REF_LSB];
    wire [2:0] grp = ctrl_r[`CTRL_GRP_LSB+2:`CTRL_GRP_LSB];
    wire apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
    wire apb_ok = addr_ok(PADDR_IN);
    wire [5:0] gidx = PADDR_IN[8:3];
    wire [15:0] freq_sel = (ref_sel == 2'h1) ? FREQ_REF2_IN :
                           (ref_sel == 2'h2) ? FREQ_REF3_IN : FREQ_REF1_IN;

    // processing cycle strobe; blocking and measurements are captured one
    // clock ahead of the stage evaluation, so the stages see this cycle's block
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            div_r <= 32'h0;
            tick_r <= 1'b0;
            eval_r <= 1'b0;
            time_r <= 32'h0;
            blk_r <= 8'h0;
            uv_r <= 1'b0;
            freq_r <= 16'h0;
            for (i = 0; i < PRE_DEPTH; i = i + 1) begin
                hist_r[i] <= 16'h0;
            end
        end else begin
            tick_r <= (div_r == CYCLE_CYC - 1);
            div_r <= (div_r == CYCLE_CYC - 1) ? 32'h0 : div_r + 32'h1;
            eval_r <= tick_r;
            if (tick_r) begin
                // a block later than one clock before expiry is too late
                blk_r <= BLOCK_IN;
                uv_r <= (uvblk_r != 16'h0) && (VOLT_IN < uvblk_r);
                freq_r <= freq_sel;
                time_r <= time_r + 32'h1;
                hist_r[0] <= freq_r;
                for (i = 1; i < PRE_DEPTH; i = i + 1) begin
                    hist_r[i] <= hist_r[i-1];
                end
            end
        end
    end

    // stages
    wire [1:0] state_w [0:NSTAGE-1];
    wire [19:0] remain_w [0:NSTAGE-1];
    wire [23:0] flag_w;
    genvar s;
    generate
        for (s = 0; s < NSTAGE; s = s + 1) begin : g_stage
            localparam [2:0] SNUM = s;
            wire [5:0] idx = {grp, SNUM}; // settings follow the active group at once
            freq_stage #(
                .IS_UNDER(s >= NSTAGE / 2)
            ) u_stage (
                .clk_in(REF_CLK_IN),
                .rst_in(RESET_IN),
                .tick_in(eval_r),
                .enable_in(enable_r[s] && used_r[idx]),
                .thr_in(thr_mem[idx]),
                .dly_in(dly_mem[idx]),
                .rel_in(rel_r),
                .rel_en_in(ctrl_r[`CTRL_RELEN_BIT]),
                .force_en_in(ctrl_r[`CTRL_FORCE_BIT]),
                .force_in(force_r[2*s+1:2*s]),
                .freq_in(freq_r),
                .blk_in(blk_r[s]),
                .uv_blk_in(uv_r && (s >= NSTAGE / 2)),
                .state_out(state_w[s]),
                .remain_out(remain_w[s])
            );
            assign flag_w[3*s+2:3*s] = flags(state_w[s]);
        end
    endgenerate
    // event detection and serialising, one event per clock
    wire [NEV-1:0] new_ev;
    generate
        for (s = 0; s < NSTAGE * 3; s = s + 1) begin : g_edge
            assign new_ev[2*s] = flag_w[s] && !flag_r[s];
            assign new_ev[2*s+1] = !flag_w[s] && flag_r[s];
        end
    endgenerate
    wire [5:0] ev_idx = first_set(pend_r);
    wire ev_any = |pend_r;
    wire [5:0] ev_stage6 = ev_idx / 6'd6;
    wire [5:0] ev_code6 = ev_idx - ev_stage6 * 6'd6;
    wire [2:0] ev_stage = ev_stage6[2:0];
    wire [2:0] ev_code = ev_code6[2:0];
    wire [NEV-1:0] served = ev_any ? ({{(NEV-1){1'b0}}, 1'b1} << ev_idx) : {NEV{1'b0}};
    wire [2:0] clr_kind = (apb_wr && PADDR_IN == `REG_CNTCLR) ? PWDATA_IN[2:0] : 3'h0;
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            flag_r <= 24'h0;
            pend_r <= {NEV{1'b0}};
            EVT_VALID_OUT <= 1'b0;
            FREQ_EVENT_BLOCK_OUT <= 3'h0;
            EVT_CODE_OUT <= 3'h0;
            EVT_TIME_OUT <= 32'h0;
            START_OUT <= 8'h0;
            TRIP_OUT <= 8'h0;
            BLOCKED_OUT <= 8'h0;
            for (j = 0; j < NSTAGE * 3; j = j + 1) begin
                cnt_mem[j] <= 16'h0;
            end
        end else begin
            flag_r <= flag_w;
            for (j = 0; j < NSTAGE; j = j + 1) begin
                START_OUT[j] <= flag_w[3*j];
                TRIP_OUT[j] <= flag_w[3*j+1];
                BLOCKED_OUT[j] <= flag_w[3*j+2];
            end
            // a new edge wins over the slot being served
            pend_r <= (pend_r & ~served) | new_ev;
            EVT_VALID_OUT <= ev_any && evmask_r[ev_code];
            FREQ_EVENT_BLOCK_OUT <= ev_stage;
            EVT_CODE_OUT <= ev_code;
            EVT_TIME_OUT <= time_r;
            // an occurrence in the clearing cycle still counts as one
            for (j = 0; j < NSTAGE * 3; j = j + 1) begin
                if (new_ev[2*j]) begin
                    cnt_mem[j] <= clr_kind[j%3] ? 16'h1 : cnt_mem[j] + 16'h1;
                end else if (clr_kind[j%3]) begin
                    cnt_mem[j] <= 16'h0;
                end
            end
        end
    end

    // only on-events of start, trip and blocked go to the log
    wire [3:0] log_ptr;
    wire [31:0] log_data;
    freq_log #(
        .DEPTH(12)
    ) u_log (
        .clk_in(REF_CLK_IN),
        .rst_in(RESET_IN),
        .wr_in(ev_any && !ev_code[0]),
        .time_in(time_r),
        .stage_in(ev_stage),
        .code_in(ev_code),
        .grp_in(grp),
        .pre_in(hist_r[PRE_DEPTH-1]),
        .fault_in(freq_r),
        .rd_idx_in(PADDR_IN[7:4]),
        .rd_word_in(PADDR_IN[3:2]),
        .rd_data_out(log_data),
        .ptr_out(log_ptr)
    );

    // register writes
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctrl_r <= `CTRL_RST;
            enable_r <= 8'h0;
            force_r <= 16'h0;
            uvblk_r <= 16'h0;
            rel_r <= `REL_RST;
            evmask_r <= `EVMASK_RST;
            used_r <= {(NSTAGE*NGRP){1'b0}};
            for (m = 0; m < NSTAGE * NGRP; m = m + 1) begin
                thr_mem[m] <= ((m % NSTAGE) >= NSTAGE / 2) ? `THR_UNDER_RST : `THR_OVER_RST;
                dly_mem[m] <= `DLY_RST;
            end
        end else if (apb_wr && apb_ok) begin
            case (PADDR_IN[11:8])
                4'h0: begin
                    case (PADDR_IN)
                        `REG_CTRL: ctrl_r <= {25'h0, PWDATA_IN[6:0]};
                        `REG_ENABLE: enable_r <= PWDATA_IN[7:0];
                        `REG_FORCE: force_r <= PWDATA_IN[15:0];
                        `REG_UVBLK: uvblk_r <= PWDATA_IN[15:0];
                        `REG_RELTIME: rel_r <= PWDATA_IN[15:0];
                        `REG_EVMASK: evmask_r <= PWDATA_IN[5:0];
                        default: ;
                    endcase
                end
                4'h2, 4'h3: begin
                    if (PADDR_IN[2]) begin
                        dly_mem[gidx] <= PWDATA_IN[18:0];
                    end else begin
                        thr_mem[gidx] <= PWDATA_IN[15:0];
                        used_r[gidx] <= PWDATA_IN[16];
                    end
                end
                default: ;
            endcase
        end
    end

    // register reads
    wire [2:0] rs = PADDR_IN[6:4];
    wire [15:0] thr_rd = thr_mem[{grp, rs}];
    wire [25:0] ratio_num = {10'h0, freq_r} * 26'd1000;
    wire [25:0] ratio_q = (thr_rd == 16'h0) ? 26'h0 : ratio_num / {10'h0, thr_rd};
    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0;
        case (PADDR_IN[11:8])
            4'h0: begin
                case (PADDR_IN)
                    `REG_CTRL: rd_val = ctrl_r;
                    `REG_ENABLE: rd_val = {24'h0, enable_r};
                    `REG_FORCE: rd_val = {16'h0, force_r};
                    `REG_UVBLK: rd_val = {16'h0, uvblk_r};
                    `REG_RELTIME: rd_val = {16'h0, rel_r};
                    `REG_EVMASK: rd_val = {26'h0, evmask_r};
                    `REG_STATUS: begin
                        for (n = 0; n < NSTAGE; n = n + 1) begin
                            rd_val[2*n+1 -: 2] = state_w[n];
                        end
                    end
                    `REG_TIME: rd_val = time_r;
                    `REG_LOGPTR: rd_val = {28'h0, log_ptr};
                    default: rd_val = 32'h0;
                endcase
            end
            4'h1: begin
                case (PADDR_IN[3:2])
                    2'h0: rd_val = {ratio_q[15:0], 14'h0, state_w[rs]};
                    2'h1: rd_val = {{12{remain_w[rs][19]}}, remain_w[rs]};
                    2'h2: rd_val = {cnt_mem[3*rs+1], cnt_mem[3*rs]};
                    default: rd_val = {16'h0, cnt_mem[3*rs+2]};
                endcase
            end
            4'h2, 4'h3: begin
                rd_val = PADDR_IN[2] ? {13'h0, dly_mem[gidx]}
                                     : {15'h0, used_r[gidx], thr_mem[gidx]};
            end
            4'h4, 4'h5, 4'h6, 4'h7: rd_val = log_data;
            default: rd_val = 32'h0;
        endcase
    end

    // read data is captured in the setup phase so the slave never waits
    always @(posedge REF_CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT <= 32'h0;
        end else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            PRDATA_OUT <= apb_ok ? rd_val : 32'h0;
        end
    end

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !apb_ok;
endmodule // freq_protection

`default_nettype wire

// *** logic/freq_stage.v ***
// one over- or underfrequency stage with definite-time trip and release hold
`timescale 1ns/100ps
`default_nettype none
`include "freq_prot_defs.vh"

module freq_stage #(
    parameter IS_UNDER = 0
) (
    // clock and cycle
    input wire clk_in,
    input wire rst_in,
    input wire tick_in,
    // settings
    input wire enable_in,
    input wire [15:0] thr_in,
    input wire [18:0] dly_in,
    input wire [15:0] rel_in,
    input wire rel_en_in,
    input wire force_en_in,
    input wire [1:0] force_in,
    // measurement and blocking
    input wire [15:0] freq_in,
    input wire blk_in,
    input wire uv_blk_in,
    // results
    output wire [1:0] state_out,
    output reg [19:0] remain_out
);
    reg pu_r;
    reg start_r;
    reg trip_r;
    reg blk_r;
    reg [18:0] cnt_r;
    reg [15:0] rel_r;
    wire [15:0] thr_hi = thr_in + `HYST_STEPS;
    wire [15:0] thr_lo = thr_in - `HYST_STEPS;
    // once picked up, drop out only 20 mHz back past the setting
    wire over_pu = pu_r ? (freq_in > thr_lo) : (freq_in > thr_in);
    wire under_pu = pu_r ? (freq_in < thr_hi) : (freq_in < thr_in);
    wire pu = enable_in && !uv_blk_in && (IS_UNDER ? under_pu : over_pu);
    wire holding = rel_en_in && (rel_r < rel_in) && (start_r || cnt_r != 19'h0);

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pu_r <= 1'b0;
            start_r <= 1'b0;
            trip_r <= 1'b0;
            blk_r <= 1'b0;
            cnt_r <= 19'h0;
            rel_r <= 16'h0;
            remain_out <= 20'h0;
        end else if (tick_in) begin
            pu_r <= pu;
            remain_out <= start_r ? ({1'b0, dly_in} - {1'b0, cnt_r}) : 20'h0;
            if (!enable_in) begin
                start_r <= 1'b0;
                trip_r <= 1'b0;
                blk_r <= 1'b0;
                cnt_r <= 19'h0;
                rel_r <= 16'h0;
            end else if (pu && blk_in) begin
                blk_r <= 1'b1;
                trip_r <= 1'b0;
                start_r <= 1'b0;
                if (holding) begin
                    rel_r <= rel_r + 16'h1;
                end else begin
                    cnt_r <= 19'h0;
                    rel_r <= 16'h0;
                end
            end else if (pu) begin
                blk_r <= 1'b0;
                start_r <= 1'b1;
                rel_r <= 16'h0;
                // zero delay trips together with start
                trip_r <= (cnt_r >= dly_in);
                if (cnt_r != 19'h7ffff) begin
                    cnt_r <= cnt_r + 19'h1;
                end
            end else begin
                blk_r <= 1'b0;
                trip_r <= 1'b0;
                if (holding) begin
                    rel_r <= rel_r + 16'h1;
                end else begin
                    start_r <= 1'b0;
                    cnt_r <= 19'h0;
                    rel_r <= 16'h0;
                end
            end
        end
    end

    assign state_out = force_en_in ? force_in :
                       blk_r ? `ST_BLOCKED :
                       trip_r ? `ST_TRIP :
                       start_r ? `ST_START : `ST_NORMAL;
endmodule // freq_stage

`default_nettype wire

// *** test/freq_protection_chk.sv ***
// port assertions for the frequency protection block
`timescale 1ns/100ps
`default_nettype none
module freq_protection_chk (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    // apb
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // stage outputs and events
    input wire logic [7:0] START_OUT,
    input wire logic [7:0] TRIP_OUT,
    input wire logic [7:0] BLOCKED_OUT,
    input wire logic EVT_VALID_OUT,
    input wire logic [2:0] FREQ_EVENT_BLOCK_OUT,
    input wire logic [2:0] EVT_CODE_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    a_ready_high: assert property (PREADY_OUT) else $error("pready low");
    a_slverr_access: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("slverr outside access");
    // read data may only move after a read setup edge
    a_rdata_stands: assert property ($changed(PRDATA_OUT) |->
        $past(PSEL_IN) && !$past(PENABLE_IN) && !$past(PWRITE_IN)) else $error("prdata moved");
    a_start_blk_excl: assert property ((START_OUT & BLOCKED_OUT) == 8'h00)
        else $error("start and blocked together");
    a_evt_code_range: assert property (EVT_VALID_OUT |-> EVT_CODE_OUT <= 3'h5)
        else $error("bad event code");
    a_start_evt_level: assert property (EVT_VALID_OUT && EVT_CODE_OUT == 3'h0 |->
        START_OUT[FREQ_EVENT_BLOCK_OUT]) else $error("start event without start");
    a_trip_evt_level: assert property (EVT_VALID_OUT && EVT_CODE_OUT == 3'h2 |->
        TRIP_OUT[FREQ_EVENT_BLOCK_OUT]) else $error("trip event without trip");
    a_blk_evt_level: assert property (EVT_VALID_OUT && EVT_CODE_OUT == 3'h4 |->
        BLOCKED_OUT[FREQ_EVENT_BLOCK_OUT]) else $error("blocked event without blocked");
    // trip holds for at least eight clocks after each move
    a_trip_per_cycle: assert property ($changed(TRIP_OUT) |=> $stable(TRIP_OUT)[*8])
        else $error("trip changed twice in a cycle");
endmodule // freq_protection_chk
bind freq_protection freq_protection_chk i_freq_protection_chk (
    .REF_CLK_IN(REF_CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .START_OUT(START_OUT),
    .TRIP_OUT(TRIP_OUT), .BLOCKED_OUT(BLOCKED_OUT), .EVT_VALID_OUT(EVT_VALID_OUT),
    .FREQ_EVENT_BLOCK_OUT(FREQ_EVENT_BLOCK_OUT), .EVT_CODE_OUT(EVT_CODE_OUT));
`default_nettype wire

// *** test/freq_src_model.sv ***
// far-side model: frequency references, voltage and blocking matrix
`timescale 1ns/100ps
`default_nettype none
module freq_src_model (
    // control from the bench
    input wire logic clk_in,
    input wire logic [15:0] f_in,
    input wire logic [1:0] ref_in,
    input wire logic [15:0] volt_in,
    input wire logic [7:0] blk_in,
    // measurements to the device
    output logic [15:0] ref1_out,
    output logic [15:0] ref2_out,
    output logic [15:0] ref3_out,
    output logic [15:0] volt_out,
    output logic [7:0] blk_out
);
    // unselected references sit at nominal so a wrong selection shows
    always @(posedge clk_in) begin
        ref1_out <= (ref_in == 2'h0) ? f_in : 16'h1388;
        ref2_out <= (ref_in == 2'h1) ? f_in : 16'h1388;
        ref3_out <= (ref_in == 2'h2) ? f_in : 16'h1388;
        volt_out <= volt_in;
        // one clock of lag, far ahead of any delay expiry
        blk_out <= blk_in;
    end
endmodule // freq_src_model
`default_nettype wire

// *** test/test_freq_protection.sv ***
// self-checking bench for the frequency protection block
`timescale 1ns/100ps
`default_nettype none
`include "freq_prot_defs.vh"
module test_freq_protection;
    logic clk, rst, psel, pen, pwr, err;
    logic [11:0] pa;
    logic [31:0] pd, rd, etm;
    logic [15:0] f, volt;
    logic [1:0] rsel;
    logic [7:0] blk;
    logic [5:0] seen, last_ev;
    wire [31:0] prdata, etime;
    wire pready, pslverr, evt;
    wire [15:0] r1, r2, r3, vm;
    wire [7:0] bm, st, tr, bl;
    wire [2:0] est, ecode;
    integer fail_count, num_checks, seed;
    freq_src_model i_freq_src_model (.clk_in(clk), .f_in(f), .ref_in(rsel), .volt_in(volt),
        .blk_in(blk), .ref1_out(r1), .ref2_out(r2), .ref3_out(r3), .volt_out(vm), .blk_out(bm));
    freq_protection #(.CYCLE_CYC(20)) i_freq_protection (.REF_CLK_IN(clk), .RESET_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pd),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .FREQ_REF1_IN(r1),
        .FREQ_REF2_IN(r2), .FREQ_REF3_IN(r3), .VOLT_IN(vm), .BLOCK_IN(bm), .START_OUT(st),
        .TRIP_OUT(tr), .BLOCKED_OUT(bl), .EVT_VALID_OUT(evt), .FREQ_EVENT_BLOCK_OUT(est),
        .EVT_CODE_OUT(ecode), .EVT_TIME_OUT(etime));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rst) begin
            seen <= 6'h00;
        end else if (evt === 1'b1 && ecode <= 3'h5) begin
            seen[ecode] <= 1'b1;
            last_ev <= {est, ecode};
            etm <= etime;
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks = num_checks + 1;
        if (s !== e) begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, pen, pwr, pa, pd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count = fail_count + 1;
            close_out();
        end
        rd = prdata;
        err = pslverr;
        {psel, pen} <= 2'b00;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, e);
    endtask
    // wait n processing cycles plus output latency
    task automatic tk(input int n);
        repeat (n * 20 + 5) @(posedge clk);
    endtask
    task automatic scheck(input int s, input logic [2:0] e);
        chk($sformatf("stage %0d", s), {29'h0, st[s], tr[s], bl[s]}, {29'h0, e});
    endtask
    initial begin
        seed = 95;
        fail_count = 0;
        num_checks = 0;
        {rst, psel, pen, pwr, pa, pd} = {4'b1000, 44'h0};
        {f, volt, blk} = {16'h1388, 16'h2710, 8'h00};
        rsel = 2'($unsigned($random(seed)) % 3);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdchk(`REG_CTRL, `CTRL_RST);
        rdchk(`REG_RELTIME, {16'h0, `REL_RST});
        rdchk(`REG_EVMASK, {26'h0, `EVMASK_RST});
        rdchk(`REG_ENABLE, 32'h0);
        rdchk(12'h200, {16'h0, `THR_OVER_RST});
        rdchk(12'h220, {16'h0, `THR_UNDER_RST});
        rdchk(12'h224, {13'h0, `DLY_RST});
        rdchk(12'h0f0, 32'h0);
        chk("slverr", {31'h0, err}, 32'h1);
        // release hold off keeps drop-out immediate
        apb(1'b1, `REG_CTRL, {30'h0, rsel});
        apb(1'b1, `REG_ENABLE, 32'hff);
        apb(1'b1, 12'h200, {15'h0, 1'b1, `THR_OVER_RST});
        apb(1'b1, 12'h204, 32'h0);
        apb(1'b1, 12'h220, {15'h0, 1'b1, `THR_UNDER_RST});
        apb(1'b1, 12'h224, 32'h3);
        f <= 16'h13ed + 16'($unsigned($random(seed)) % 500);
        tk(2);
        scheck(0, 3'b110);
        scheck(1, 3'b000);
        f <= 16'h13eb;
        tk(2);
        scheck(0, 3'b110);
        f <= 16'h13e9;
        tk(2);
        scheck(0, 3'b000);
        rdchk(12'h108, 32'h0001_0001);
        apb(1'b1, `REG_CNTCLR, 32'h7);
        rdchk(12'h108, 32'h0);
        rdchk(12'h414, 32'h2);
        f <= 16'h1323;
        tk(2);
        scheck(4, 3'b100);
        tk(4);
        scheck(4, 3'b110);
        f <= 16'h1388;
        tk(2);
        {blk, f} <= {8'h10, 16'h1323};
        tk(2);
        scheck(4, 3'b001);
        tk(4);
        scheck(4, 3'b001);
        {blk, f} <= {8'h00, 16'h1388};
        tk(2);
        f <= 16'h1323;
        tk(1);
        blk <= 8'h10;
        tk(2);
        chk("late block", {30'h0, st[4], tr[4]}, 32'h0);
        {blk, f} <= {8'h00, 16'h1388};
        tk(2);
        apb(1'b1, `REG_UVBLK, 32'h1388);
        {volt, f} <= {16'h0fa0, 16'h1323};
        tk(2);
        scheck(4, 3'b000);
        apb(1'b1, `REG_ENABLE, 32'h0);
        volt <= 16'h2710;
        tk(2);
        scheck(4, 3'b000);
        chk("events", {26'h0, seen}, 32'h3f);
        f <= 16'h1388;
        apb(1'b1, `REG_ENABLE, 32'hff);
        apb(1'b1, `REG_FORCE, 32'h8);
        apb(1'b1, `REG_CTRL, {29'h0, 1'b1, rsel});
        apb(1'b0, `REG_TIME, 32'h0);
        tk(2);
        chk("forced trip", {31'h0, tr[1]}, 32'h1);
        chk("last event", {26'h0, last_ev}, 32'h0a);
        chk("event time", {31'h0, (etm - rd) <= 32'h1}, 32'h1);
        rdchk(`REG_LOGPTR, 32'h9);
        rdchk(12'h100, 32'h03d4_0000);
        close_out();
    end
endmodule // test_freq_protection
`default_nettype wire
